/* logic/segment_classifier.v */
/*
 combinational classifier: maps a bus address to a main memory segment
 from the two page borders.
 assumes the page shift matches the implemented main memory size.
*/
`timescale 1ns/1ps
`include "segment_protector_consts.vh"

module segment_classifier
#(
   parameter ADDR_W = `ADDR_W,
   parameter [15:0] MAIN_START = `MAIN_START_DEFAULT,
   parameter [15:0] MAIN_END = `MAIN_END_DEFAULT,
   parameter PAGE_SHIFT = `PAGE_SHIFT_DEFAULT
)
(
   input wire [ADDR_W-1:0] address,
   input wire [`BORDER_W-1:0] lower_border,
   input wire [`BORDER_W-1:0] upper_border,
   output reg [1:0] segment
);
   wire in_main;
   wire [ADDR_W-1:0] offset;
   wire [`BORDER_W-1:0] page;

   assign in_main = (address >= MAIN_START) && (address <= MAIN_END);
   assign offset = address - MAIN_START;
   // five top bits of the offset pick one of 32 pages [R8] [R12] [R13]
   assign page = offset[PAGE_SHIFT+`BORDER_W-1:PAGE_SHIFT];

   always @*
   begin
      if (!in_main)
         segment = `SEG_NONE; // [R15]
      else if (page < lower_border && page < upper_border)
         segment = `SEG_ONE; // [R9] [R10]
      else if (page >= upper_border)
         // equal borders leave no room for segment two [R11]
         segment = `SEG_THREE; // [R10]
      else
         segment = `SEG_TWO; // border page belongs above it [R14]
   end
endmodule

/* logic/segment_protector.v */
/*
 main memory segment protector: password-guarded configuration, segment
 lookup on the memory address bus and a registered access verdict.
 assumes the core drives address, fetch and write strobes synchronous to
 CLOCK and that RESETN is the brown-out reset.
*/
`timescale 1ns/1ps
`include "segment_protector_consts.vh"

// How it works
// R1: while enabled, writes to read-only and fetches from no-exec segments are blocked.
// R2: with the enable bit clear, every access is allowed.
// R3: after brown-out reset, no segments and full access everywhere.
// R4: main memory splits into up to three segments with own rights.
// R5: information memory has its own independent rights.
// R6: configuration changes only with the correct password.
// R7: lower and upper borders are five-bit fields of the border register.
// R8: one page is one thirty-second of main memory.
// R9: segments run start-to-lower, lower-to-upper, upper-to-end.
// R10: each bus address is compared against both borders.
// R11: equal borders give only two segments.
// R12: each border field gives the five top bits of the border address.
// R13: main memory is always 32 pages, zero to thirty-one.
// R14: an address at the lower border is in segment two.
// R15: addresses outside main and information memory go unchecked.
module segment_protector
#(
   parameter ADDR_W = `ADDR_W,
   parameter [15:0] MAIN_START = `MAIN_START_DEFAULT,
   parameter [15:0] MAIN_END = `MAIN_END_DEFAULT,
   parameter PAGE_SHIFT = `PAGE_SHIFT_DEFAULT,
   parameter [15:0] INFO_START = `INFO_START_DEFAULT,
   parameter [15:0] INFO_END = `INFO_END_DEFAULT
)
(
   input wire CLOCK,
   input wire RESETN,
   input wire CONFIG_WRITE,
   input wire [`PASSWORD_W-1:0] CONFIG_PASSWORD,
   input wire CONFIG_ENABLE,
   input wire [`BORDER_W-1:0] CONFIG_LOWER_BORDER,
   input wire [`BORDER_W-1:0] CONFIG_UPPER_BORDER,
   input wire [`RIGHTS_W-1:0] CONFIG_SEG1_RIGHTS,
   input wire [`RIGHTS_W-1:0] CONFIG_SEG2_RIGHTS,
   input wire [`RIGHTS_W-1:0] CONFIG_SEG3_RIGHTS,
   input wire [`RIGHTS_W-1:0] CONFIG_INFO_RIGHTS,
   input wire [ADDR_W-1:0] MEMORY_ADDRESS_BUS,
   input wire ACCESS_VALID,
   input wire ACCESS_WRITE,
   input wire ACCESS_FETCH,
   output reg PROTECTION_ENABLE,
   output reg [`BORDER_W-1:0] LOWER_BORDER_FIELD,
   output reg [`BORDER_W-1:0] UPPER_BORDER_FIELD,
   output reg CONFIG_REJECTED,
   output reg [1:0] ACCESS_SEGMENT,
   output reg ACCESS_INFO,
   output reg ACCESS_ALLOWED,
   output reg ACCESS_BLOCKED
);
   localparam SEGMENTS = 3;
   localparam TABLE_W = (SEGMENTS + 1) * `RIGHTS_W;
   localparam IN_W = SEGMENTS * `RIGHTS_W;

   wire [IN_W-1:0] rights_in;
   wire [TABLE_W-1:0] rights_table;
   reg [`RIGHTS_W-1:0] info_rights_q;
   reg [`RIGHTS_W-1:0] info_rights_d;
   reg enable_d;
   reg [`BORDER_W-1:0] lower_d;
   reg [`BORDER_W-1:0] upper_d;
   reg rejected_d;
   reg [`RIGHTS_W-1:0] rights;
   reg checked;
   reg violation;
   reg [1:0] segment_d;
   reg info_d;
   reg allowed_d;
   reg blocked_d;
   wire [1:0] segment;
   wire in_info;
   wire key_ok;
   wire config_load;
   genvar g;

   segment_classifier
   #(
      .ADDR_W(ADDR_W),
      .MAIN_START(MAIN_START),
      .MAIN_END(MAIN_END),
      .PAGE_SHIFT(PAGE_SHIFT)
   )
   u_classifier
   (
      .address(MEMORY_ADDRESS_BUS),
      .lower_border(LOWER_BORDER_FIELD),
      .upper_border(UPPER_BORDER_FIELD),
      .segment(segment)
   );

   assign in_info = (MEMORY_ADDRESS_BUS >= INFO_START) &&
      (MEMORY_ADDRESS_BUS <= INFO_END);
   assign key_ok = (CONFIG_PASSWORD == `PASSWORD_KEY);
   // a write with the wrong key changes no configuration, it only raises CONFIG_REJECTED [R6]
   assign config_load = CONFIG_WRITE && key_ok;
   assign rights_in = {CONFIG_SEG3_RIGHTS, CONFIG_SEG2_RIGHTS,
      CONFIG_SEG1_RIGHTS};

   // one rights register per segment; slot zero is a fixed open entry, but
   // the lookup never indexes it: an unmapped address skips the table
   generate
      for (g = 0; g <= SEGMENTS; g = g + 1)
      begin : seg_entry
         if (g == 0)
         begin : open_slot
            assign rights_table[`RIGHTS_W-1:0] = `RIGHTS_OPEN;
         end
         else
         begin : held_slot
            reg [`RIGHTS_W-1:0] rights_q;
            always @(posedge CLOCK or negedge RESETN)
            begin
               if (!RESETN)
                  rights_q <= `RIGHTS_OPEN; // [R3]
               else if (config_load)
                  rights_q <= rights_in[(g-1)*`RIGHTS_W +: `RIGHTS_W]; // [R4]
            end
            assign rights_table[g*`RIGHTS_W +: `RIGHTS_W] = rights_q;
         end
      end
   endgenerate

   // next configuration; all fields move together on an accepted write
   always @*
   begin
      enable_d = PROTECTION_ENABLE;
      lower_d = LOWER_BORDER_FIELD;
      upper_d = UPPER_BORDER_FIELD;
      info_rights_d = info_rights_q;
      rejected_d = CONFIG_WRITE && !key_ok; // [R6]
      if (config_load) // [R6]
      begin
         enable_d = CONFIG_ENABLE; // [R2]
         lower_d = CONFIG_LOWER_BORDER; // [R7]
         upper_d = CONFIG_UPPER_BORDER; // [R7]
         info_rights_d = CONFIG_INFO_RIGHTS; // [R5]
      end
   end

   // configuration; reset is the brown-out reset, leaving everything open
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         PROTECTION_ENABLE <= `ENABLE_RESET; // [R3]
         LOWER_BORDER_FIELD <= `BORDER_RESET; // [R3]
         UPPER_BORDER_FIELD <= `BORDER_RESET;
         info_rights_q <= `RIGHTS_OPEN; // [R3]
         CONFIG_REJECTED <= 1'b0;
      end
      else
      begin
         PROTECTION_ENABLE <= enable_d;
         LOWER_BORDER_FIELD <= lower_d;
         UPPER_BORDER_FIELD <= upper_d;
         info_rights_q <= info_rights_d;
         CONFIG_REJECTED <= rejected_d;
      end
   end

   // rights lookup; entry zero is never read, unmapped addresses default to open
   always @*
   begin
      rights = `RIGHTS_OPEN;
      checked = 1'b0;
      if (segment != `SEG_NONE)
      begin
         rights = rights_table[segment*`RIGHTS_W +: `RIGHTS_W]; // [R4]
         checked = 1'b1;
      end
      else if (in_info)
      begin
         rights = info_rights_q; // [R5]
         checked = 1'b1;
      end
      // disabled unit checks nothing [R2]; unmapped passes [R15]
      violation = PROTECTION_ENABLE && checked && ACCESS_VALID &&
         ((ACCESS_WRITE && !rights[`RIGHT_WRITE]) ||
         (ACCESS_FETCH && !rights[`RIGHT_EXEC]) ||
         (!ACCESS_WRITE && !ACCESS_FETCH && !rights[`RIGHT_READ])); // [R1]
   end

   // verdict; a blocked access still reports its segment, so the core can
   // tell which border setting caught it
   always @*
   begin
      segment_d = `SEG_NONE;
      info_d = 1'b0;
      allowed_d = 1'b0;
      blocked_d = violation; // [R1]
      if (ACCESS_VALID)
      begin
         segment_d = segment; // [R10]
         info_d = in_info;
         allowed_d = !violation; // [R2]
      end
   end

   // verdict registered one cycle after the access is presented
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ACCESS_SEGMENT <= `SEG_NONE;
         ACCESS_INFO <= 1'b0;
         ACCESS_ALLOWED <= 1'b0;
         ACCESS_BLOCKED <= 1'b0;
      end
      else
      begin
         ACCESS_SEGMENT <= segment_d;
         ACCESS_INFO <= info_d;
         ACCESS_ALLOWED <= allowed_d;
         ACCESS_BLOCKED <= blocked_d;
      end
   end
endmodule

/* logic/segment_protector_consts.vh */
/*
 constants for the main memory segment protector: password, reset values,
 address map and field widths.
 assumes a 16-bit memory address bus and a main memory ending at ffffh.
*/
`ifndef SEGMENT_PROTECTOR_CONSTS_VH
`define SEGMENT_PROTECTOR_CONSTS_VH

`define ADDR_W 16
`define BORDER_W 5
`define PAGE_COUNT 32
`define PASSWORD_W 8
`define PASSWORD_KEY 8'hA5
`define MAIN_START_DEFAULT 16'hC000
`define MAIN_END_DEFAULT 16'hFFFF
`define PAGE_SHIFT_DEFAULT 9
`define INFO_START_DEFAULT 16'h1800
`define INFO_END_DEFAULT 16'h19FF
`define RIGHTS_W 3
`define RIGHT_READ 0
`define RIGHT_WRITE 1
`define RIGHT_EXEC 2
`define RIGHTS_OPEN 3'h7
`define BORDER_RESET 5'h00
`define ENABLE_RESET 1'b0
`define SEG_NONE 2'h0
`define SEG_ONE 2'h1
`define SEG_TWO 2'h2
`define SEG_THREE 2'h3

`endif

/* verification/core_model.sv */
/*
 core model: puts one access per cycle on the memory address bus.
 assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module core_model
(
   input wire CLOCK,
   output reg [15:0] MEMORY_ADDRESS_BUS = 16'h0000,
   output reg ACCESS_VALID = 1'b0,
   output reg ACCESS_WRITE = 1'b0,
   output reg ACCESS_FETCH = 1'b0
);
   task access(input [15:0] a, input w, input f, input v);
   begin
      @(posedge CLOCK);
      #1;
      // idle bus shows the inverted address, not a stale one
      MEMORY_ADDRESS_BUS = v ? a : ~MEMORY_ADDRESS_BUS;
      ACCESS_VALID = v;
      ACCESS_WRITE = w;
      ACCESS_FETCH = f;
   end
   endtask
endmodule

/* verification/segment_protector_assertions.sv */
/*
 checker for the segment protector ports: config password, verdicts and
 segment choice. assumes 16KB main memory at c000h, info in page 0ch.
*/
`timescale 1ns/1ps
module segment_protector_assertions
(
   input wire CLOCK,
   input wire RESETN,
   input wire CONFIG_WRITE,
   input wire [7:0] CONFIG_PASSWORD,
   input wire CONFIG_ENABLE,
   input wire [15:0] MEMORY_ADDRESS_BUS,
   input wire ACCESS_VALID,
   input wire PROTECTION_ENABLE,
   input wire [4:0] LOWER_BORDER_FIELD,
   input wire [4:0] UPPER_BORDER_FIELD,
   input wire CONFIG_REJECTED,
   input wire [1:0] ACCESS_SEGMENT,
   input wire ACCESS_ALLOWED,
   input wire ACCESS_BLOCKED
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   wire [4:0] pg = MEMORY_ADDRESS_BUS[13:9];
   wire mn = ACCESS_VALID && MEMORY_ADDRESS_BUS >= 16'hC000;
   // info memory is the 512-byte block 1800h-19ffh
   wire out = ACCESS_VALID && !mn && MEMORY_ADDRESS_BUS[15:9] != 7'h0C;
   property p_reject;
      CONFIG_WRITE && CONFIG_PASSWORD != 8'hA5
         |=> CONFIG_REJECTED && $stable(PROTECTION_ENABLE);
   endproperty
   a_reject: assert property (p_reject) else $error("bad write applied");
   property p_accept;
      CONFIG_WRITE && CONFIG_PASSWORD == 8'hA5 |=> !CONFIG_REJECTED
         && PROTECTION_ENABLE == $past(CONFIG_ENABLE);
   endproperty
   a_accept: assert property (p_accept) else $error("write lost");
   property p_off;
      !PROTECTION_ENABLE && ACCESS_VALID |=> ACCESS_ALLOWED;
   endproperty
   a_off: assert property (p_off) else $error("blocked while off");
   property p_one;
      ACCESS_VALID |=> ACCESS_ALLOWED != ACCESS_BLOCKED;
   endproperty
   a_one: assert property (p_one) else $error("no single verdict");
   property p_out;
      out |=> ACCESS_SEGMENT == 2'h0 && ACCESS_ALLOWED;
   endproperty
   a_out: assert property (p_out) else $error("outside checked");
   property p_seg1;
      mn && pg < LOWER_BORDER_FIELD && pg < UPPER_BORDER_FIELD
         |=> ACCESS_SEGMENT == 2'h1;
   endproperty
   a_seg1: assert property (p_seg1) else $error("not segment 1");
   property p_seg2;
      mn && pg == LOWER_BORDER_FIELD && pg < UPPER_BORDER_FIELD
         |=> ACCESS_SEGMENT == 2'h2;
   endproperty
   a_seg2: assert property (p_seg2) else $error("not segment 2");
   property p_seg3;
      mn && pg >= UPPER_BORDER_FIELD |=> ACCESS_SEGMENT == 2'h3;
   endproperty
   a_seg3: assert property (p_seg3) else $error("not segment 3");
   c_block: cover property (ACCESS_BLOCKED);
   c_reject: cover property (CONFIG_REJECTED);
   c_equal: cover property (mn && LOWER_BORDER_FIELD == UPPER_BORDER_FIELD);
endmodule
bind segment_protector segment_protector_assertions chk (.*);

/* verification/segment_protector_bench.sv */
/*
 bench: config writes and accesses, expectations queued and checked by a
 watcher. assumes 16KB main memory at c000h and info at 1800h-19ffh.
*/
`timescale 1ns/1ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
 $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module segment_protector_bench;
   reg CLOCK = 0, RESETN = 0, CONFIG_WRITE = 0, CONFIG_ENABLE = 0;
   reg [7:0] CONFIG_PASSWORD = 8'h00;
   reg [4:0] CONFIG_LOWER_BORDER = 5'h00, CONFIG_UPPER_BORDER = 5'h00;
   reg [2:0] CONFIG_SEG1_RIGHTS = 3'h7, CONFIG_SEG2_RIGHTS = 3'h7;
   reg [2:0] CONFIG_SEG3_RIGHTS = 3'h7, CONFIG_INFO_RIGHTS = 3'h7;
   wire [15:0] MEMORY_ADDRESS_BUS;
   wire ACCESS_VALID, ACCESS_WRITE, ACCESS_FETCH, ACCESS_INFO;
   wire PROTECTION_ENABLE, CONFIG_REJECTED, ACCESS_ALLOWED, ACCESS_BLOCKED;
   wire [4:0] LOWER_BORDER_FIELD, UPPER_BORDER_FIELD;
   wire [1:0] ACCESS_SEGMENT;
   reg [22:0] s = {11'h000, 12'hFFF};
   reg [4:0] q[$];
   reg [4:0] note;
   reg [15:0] t [0:7] = '{16'hD600, 16'hD800, 16'hEC00, 16'hEE00,
      16'hFFFF, 16'h1800, 16'h1A00, 16'h0400};
   int n_errors = 0, n_compared = 0;
   always #2.5 CLOCK = ~CLOCK;
   core_model core (.*);
   segment_protector dut (.*);
   function [4:0] expect_of(input [15:0] x, input w, input f);
      reg [2:0] r, need;
      reg [1:0] g;
      reg i, ok;
      begin
         i = x[15:9] == 7'h0C;
         g = x < 16'hC000 ? 2'h0 : x[13:9] >= s[16:12] ? 2'h3 :
            x[13:9] < s[21:17] ? 2'h1 : 2'h2;
         r = i ? s[2:0] : g == 2'h1 ? s[11:9] : g == 2'h2 ? s[8:6] :
            g == 2'h3 ? s[5:3] : 3'h7;
         need = {f, w, !(w | f)};
         ok = !s[22] || (r & need) == need;
         expect_of = {g, i, ok, !ok};
      end
   endfunction
   task go(input [15:0] x, input w, input f);
   begin
      core.access(x, w, f, 1'b1);
      q.push_back(expect_of(x, w, f));
   end
   endtask
   task cfg(input [7:0] p, input e, input [9:0] b, input [11:0] r);
   begin
      @(posedge CLOCK);
      #1;
      CONFIG_WRITE = 1;
      CONFIG_PASSWORD = p;
      {CONFIG_ENABLE, CONFIG_LOWER_BORDER, CONFIG_UPPER_BORDER} = {e, b};
      {CONFIG_SEG1_RIGHTS, CONFIG_SEG2_RIGHTS, CONFIG_SEG3_RIGHTS,
         CONFIG_INFO_RIGHTS} = r;
      if (p == 8'hA5) s = {e, b, r};
      @(posedge CLOCK);
      #1;
      CONFIG_WRITE = 0;
      `CHECK({CONFIG_REJECTED, PROTECTION_ENABLE}, {p != 8'hA5, s[22]})
      `CHECK({LOWER_BORDER_FIELD, UPPER_BORDER_FIELD}, s[21:12])
   end
   endtask
   task sweep;
   begin
      for (int k = 0; k < 32; k++) go(t[k / 4], k[0], k[1]);
      repeat (40) go({2'h3, 14'($urandom)}, 1'($urandom), 1'($urandom));
      // drop valid so that no stray verdicts follow the last access
      core.access(16'h0000, 1'b0, 1'b0, 1'b0);
   end
   endtask
   task report_and_stop;
   begin
      $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   always @(posedge CLOCK)
   begin
      #1;
      if (ACCESS_ALLOWED | ACCESS_BLOCKED)
      begin
         note = q.pop_front();
         `CHECK(ACCESS_SEGMENT, note[4:3])
         `CHECK(ACCESS_INFO, note[2])
         `CHECK(ACCESS_ALLOWED, note[1])
         `CHECK(ACCESS_BLOCKED, note[0])
      end
   end
   initial
   begin
      #100000;
      n_errors++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(17700));
      repeat (12) @(posedge CLOCK);
      #1 RESETN = 1;
      sweep;
      // seg1 r, seg2 rw, seg3 rx, info r
      cfg(8'h96, 1'b1, 10'h197, 12'h2E9);
      cfg(8'hA5, 1'b1, 10'h197, 12'h2E9);
      sweep;
      cfg(8'hA5, 1'b1, 10'h14A, 12'h2E9);
      sweep;
      cfg(8'hA5, 1'b0, 10'h197, 12'h000);
      sweep;
      cfg(8'hA5, 1'b1, 10'h197, 12'h000);
      core.access(16'h0000, 1'b0, 1'b0, 1'b0);
      @(posedge CLOCK);
      #1 RESETN = 0;
      s = {11'h000, 12'hFFF};
      #5 RESETN = 1;
      `CHECK({PROTECTION_ENABLE, LOWER_BORDER_FIELD}, 6'h00)
      sweep;
      core.access(16'h0000, 1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge CLOCK);
      `CHECK(q.size(), 0)
      report_and_stop;
   end
endmodule
